/* File: core/mlfc_pkg.sv */
// Purpose: Constants, types and decoders for the motor lock fault settings block
// Assumes: APB slave, 20 MHz pclk, register indices times four give byte addresses
// Notes: Summary of operation below
//
// Summary of operation
// - 32-bit RW settings register, index 92h, resets zero
// - Bit 30 enables abnormal speed detector
// - Bit 29 enables abnormal back-EMF detector
// - Bit 28 enables no-motor detector
// - Bits 27:25 speed threshold, 130 to 200 percent
// - Bits 24:22 back-EMF threshold, 40 to 70 percent
// - Bits 21:19 no-motor current threshold, 0.075-1.0 A
// - Bits 14:12 current-limit lock deglitch, 0-7 us
package mlfc_pkg;

    localparam logic [9:0] LFS_IDX = 10'h092;
    localparam logic [9:0] STS_IDX = 10'h093;
    localparam logic [9:0] MSK_IDX = 10'h094;
    localparam logic [9:0] FLT_IDX = 10'h095;

    localparam logic [31:0] LFS_RESET = 32'h00000000;

    localparam int SPEED_EN_BIT = 30;
    localparam int BEMF_EN_BIT = 29;
    localparam int NOMTR_EN_BIT = 28;
    localparam int SPEED_THR_LSB = 25;
    localparam int BEMF_THR_LSB = 22;
    localparam int NOMTR_THR_LSB = 19;
    localparam int ACTION_LSB = 15;
    localparam int DGL_LSB = 12;

    localparam int NUM_EV = 4;
    localparam int EV_SPEED = 0;
    localparam int EV_BEMF = 1;
    localparam int EV_NOMTR = 2;
    localparam int EV_HWLOCK = 3;

    localparam logic [3:0] ACTION_OFF_MIN = 4'h9;

    localparam int CLK_PERIOD_NS = 50;
    localparam int DGL_STEP_NS = 1000;
    localparam int DGL_STEP_CYC = DGL_STEP_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic valid;
        logic [7:0] speed_pct;
        logic [9:0] bemf_pm;
        logic [10:0] current_ma;
        logic ilimit;
    } mlfc_meas_t;

    typedef struct packed {
        logic [7:0] speed_pct;
        logic [9:0] bemf_pm;
        logic [10:0] current_ma;
        logic [2:0] dgl_us;
        logic [3:0] action;
    } mlfc_thr_t;

    typedef struct packed {
        logic [31:0] cfg;
        logic [NUM_EV-1:0] sts;
        logic [NUM_EV-1:0] msk;
        logic [NUM_EV-1:0] flt;
        logic [7:0] dgl_cnt;
        logic [31:0] rdata;
    } mlfc_state_t;

    function automatic logic [7:0] speed_thr(input logic [2:0] code);
        speed_thr = 8'h82 + 8'({code, 3'b000}) + 8'({code, 1'b0});
    endfunction : speed_thr

    function automatic logic [9:0] bemf_thr(input logic [2:0] code);
        unique case (code)
            3'h0: bemf_thr = 10'h190;
            3'h1: bemf_thr = 10'h1C2;
            3'h2: bemf_thr = 10'h1F4;
            3'h3: bemf_thr = 10'h226;
            3'h4: bemf_thr = 10'h258;
            3'h5: bemf_thr = 10'h28A;
            3'h6: bemf_thr = 10'h2A3;
            3'h7: bemf_thr = 10'h2BC;
        endcase
    endfunction : bemf_thr

    function automatic logic [10:0] nomtr_thr(input logic [2:0] code);
        unique case (code)
            3'h0: nomtr_thr = 11'h04B;
            3'h1: nomtr_thr = 11'h04B;
            3'h2: nomtr_thr = 11'h064;
            3'h3: nomtr_thr = 11'h07D;
            3'h4: nomtr_thr = 11'h0FA;
            3'h5: nomtr_thr = 11'h1F4;
            3'h6: nomtr_thr = 11'h2EE;
            3'h7: nomtr_thr = 11'h3E8;
        endcase
    endfunction : nomtr_thr

    function automatic logic [7:0] dgl_limit(input logic [2:0] code);
        dgl_limit = 8'(int'(code) * DGL_STEP_CYC);
    endfunction : dgl_limit

endpackage : mlfc_pkg

/* File: core/mlfc_core.sv */
// Purpose: Lock fault settings register, lock detectors and fault interrupt
// Assumes: Measurements synchronous to pclk; APB master keeps the protocol
// Notes: Zero wait states; read data is captured in the setup cycle
//
// Chosen here: register access over APB.
module mlfc_core
    import mlfc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire mlfc_meas_t meas,
    output mlfc_thr_t thr,
    output logic [NUM_EV-1:0] fault,
    output logic irq
);

    mlfc_state_t s_q;
    mlfc_state_t s_d;
    logic [9:0] idx;
    logic addr_ok;
    logic setup;
    logic acc_wr;
    logic [NUM_EV-1:0] en;
    logic [NUM_EV-1:0] ev;
    logic hw_on;
    logic [7:0] lim;

    assign idx = paddr[11:2];
    assign addr_ok = (paddr[1:0] == 2'h0)
        && (idx == LFS_IDX || idx == STS_IDX || idx == MSK_IDX || idx == FLT_IDX);
    assign setup = psel & ~penable;
    assign acc_wr = psel & penable & pwrite & addr_ok;
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~addr_ok;
    assign prdata = s_q.rdata;
    assign fault = s_q.flt;
    assign irq = |(s_q.sts & s_q.msk);

    // Decoded thresholds for the detectors
    assign thr.speed_pct = speed_thr(s_q.cfg[SPEED_THR_LSB+:3]);
    assign thr.bemf_pm = bemf_thr(s_q.cfg[BEMF_THR_LSB+:3]);
    assign thr.current_ma = nomtr_thr(s_q.cfg[NOMTR_THR_LSB+:3]);
    assign thr.dgl_us = s_q.cfg[DGL_LSB+:3];
    assign thr.action = s_q.cfg[ACTION_LSB+:4];

    assign hw_on = (thr.action < ACTION_OFF_MIN);
    assign lim = dgl_limit(thr.dgl_us);
    assign en = {hw_on, s_q.cfg[NOMTR_EN_BIT], s_q.cfg[BEMF_EN_BIT],
        s_q.cfg[SPEED_EN_BIT]};

    always_comb
    begin
        s_d = s_q;
        // Detectors evaluated on each valid measurement
        if (meas.valid)
        begin
            s_d.flt[EV_SPEED] = meas.speed_pct > thr.speed_pct;
            s_d.flt[EV_BEMF] = meas.bemf_pm < thr.bemf_pm;
            s_d.flt[EV_NOMTR] = meas.current_ma < thr.current_ma;
        end
        // Current-limit deglitch counts consecutive high cycles
        if (meas.ilimit)
        begin
            if (s_q.dgl_cnt != 8'hFF)
            begin
                s_d.dgl_cnt = s_q.dgl_cnt + 8'h01;
            end
        end
        else
        begin
            s_d.dgl_cnt = 8'h00;
        end
        s_d.flt[EV_HWLOCK] = meas.ilimit && (s_q.dgl_cnt >= lim);
        s_d.flt = s_d.flt & en;
        ev = s_d.flt & ~s_q.flt;
        if (acc_wr)
        begin
            unique case (idx)
                LFS_IDX: s_d.cfg = pwdata;
                STS_IDX: s_d.sts = s_q.sts & ~pwdata[NUM_EV-1:0];
                MSK_IDX: s_d.msk = pwdata[NUM_EV-1:0];
                default: s_d.msk = s_q.msk;
            endcase
        end
        // New events win over a clear in the same cycle
        s_d.sts = s_d.sts | ev;
        if (setup)
        begin
            unique case (idx)
                LFS_IDX: s_d.rdata = s_q.cfg;
                STS_IDX: s_d.rdata = {28'h0000000, s_q.sts};
                MSK_IDX: s_d.rdata = {28'h0000000, s_q.msk};
                FLT_IDX: s_d.rdata = {28'h0000000, s_q.flt};
                default: s_d.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_q <= '{cfg: LFS_RESET, sts: 4'h0, msk: 4'h0, flt: 4'h0,
                dgl_cnt: 8'h00, rdata: 32'h00000000};
        end
        else
        begin
            s_q <= s_d;
        end
    end

    sequence s_cfg_write;
        psel && penable && pwrite && paddr == {LFS_IDX, 2'b00};
    endsequence

    sequence s_cfg_read;
        psel && !penable && !pwrite && paddr == {LFS_IDX, 2'b00} ##1 psel && penable;
    endsequence

    a_cfg_write_store: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_write |=> s_q.cfg == $past(pwdata))
        else $error("settings write not stored");

    a_cfg_read_back: assert property (@(posedge pclk) disable iff (!presetn)
        s_cfg_read |-> prdata == s_q.cfg)
        else $error("settings read mismatch");

    a_speed_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.cfg[SPEED_EN_BIT] |=> !fault[EV_SPEED])
        else $error("speed fault while disabled");

    a_bemf_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.cfg[BEMF_EN_BIT] |=> !fault[EV_BEMF])
        else $error("back-EMF fault while disabled");

    a_nomtr_gate_off: assert property (@(posedge pclk) disable iff (!presetn)
        !s_q.cfg[NOMTR_EN_BIT] |=> !fault[EV_NOMTR])
        else $error("no-motor fault while disabled");

    a_speed_thr_hit: assert property (@(posedge pclk) disable iff (!presetn)
        meas.valid && s_q.cfg[SPEED_EN_BIT]
        |=> fault[EV_SPEED] == ($past(meas.speed_pct) > 8'(130 + 10 * int'($past(
        s_q.cfg[SPEED_THR_LSB+:3])))))
        else $error("speed threshold compare wrong");

    a_bemf_thr_hit: assert property (@(posedge pclk) disable iff (!presetn)
        meas.valid && s_q.cfg[BEMF_EN_BIT] && s_q.cfg[BEMF_THR_LSB+:3] == 3'h6
        |=> fault[EV_BEMF] == ($past(meas.bemf_pm) < 10'h2A3))
        else $error("back-EMF threshold compare wrong");

    a_nomtr_thr_hit: assert property (@(posedge pclk) disable iff (!presetn)
        meas.valid && s_q.cfg[NOMTR_EN_BIT] && s_q.cfg[NOMTR_THR_LSB+:3] <= 3'h1
        |=> fault[EV_NOMTR] == ($past(meas.current_ma) < 11'h04B))
        else $error("no-motor threshold compare wrong");

    a_dgl_one_us: assert property (@(posedge pclk) disable iff (!presetn)
        (hw_on && thr.dgl_us == 3'h1 && !meas.ilimit) ##1
        (meas.ilimit && hw_on && thr.dgl_us == 3'h1) [*8] ##1
        (meas.ilimit && hw_on && thr.dgl_us == 3'h1)
        |=> !fault[EV_HWLOCK])
        else $error("current-limit fault before deglitch");

    a_hw_action_off: assert property (@(posedge pclk) disable iff (!presetn)
        !hw_on |=> !fault[EV_HWLOCK])
        else $error("current-limit fault while action disabled");

    a_hw_sts_set: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(fault[EV_HWLOCK]) |-> s_q.sts[EV_HWLOCK])
        else $error("current-limit event not recorded");

    a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(fault[EV_SPEED]) |=> s_q.sts[EV_SPEED] && (irq == s_q.msk[EV_SPEED] || irq))
        else $error("speed event not recorded");

endmodule : mlfc_core

/* File: testbench/tb_motor_lock_fault_config.sv */
// Purpose: Self-checking bench for the lock fault settings block over APB
// Assumes: Up to 14 wait states; pready is polled under a bound of 16 edges
// Notes: Register, decoder, detector, interrupt and deglitch checks
module tb_motor_lock_fault_config import mlfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    mlfc_meas_t meas = '0;
    mlfc_thr_t thr;
    logic [NUM_EV-1:0] fault;
    int bad_count = 0;
    int checked = 0;
    logic [31:0] rd;
    logic er;
    logic [9:0] bemf_tab [8] = '{10'h190, 10'h1C2, 10'h1F4, 10'h226,
                                 10'h258, 10'h28A, 10'h2A3, 10'h2BC};
    logic [10:0] cur_tab [8] = '{11'h04B, 11'h04B, 11'h064, 11'h07D,
                                 11'h0FA, 11'h1F4, 11'h2EE, 11'h3E8};

    mlfc_core u_dut (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .meas(meas),
        .thr(thr),
        .fault(fault),
        .irq(irq)
    );

    initial
    begin
        forever #25 pclk = ~pclk;
    end

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask : chk

    // One APB transfer; read data and error taken at the ready edge
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16)
        begin
            bad_count++;
            tally_and_finish();
        end
    endtask : apb

    // One valid measurement sample, fault looked at after its edge
    task automatic smp(input logic [7:0] s, input logic [9:0] b, input logic [10:0] c);
        meas.valid <= 1'b1;
        meas.speed_pct <= s;
        meas.bemf_pm <= b;
        meas.current_ma <= c;
        @(posedge pclk);
        meas.valid <= 1'b0;
        #1;
    endtask : smp

    initial
    begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, LFS_IDX, 32'h00000000);
        chk("settings reset", rd, LFS_RESET);
        apb(1'b1, LFS_IDX, 32'hFFFFFFFF);
        apb(1'b0, LFS_IDX, 32'h00000000);
        chk("settings all ones", rd, 32'hFFFFFFFF);
        for (int c = 0; c < 8; c++)
        begin
            apb(1'b1, LFS_IDX, (32'(c) << 25) | (32'(c) << 22) | (32'(c) << 19) | (32'(c) << 12));
            #1;
            chk("speed thr", thr.speed_pct, 32'h82 + 32'(c) * 32'h0A);
            chk("bemf thr", thr.bemf_pm, bemf_tab[c]);
            chk("current thr", thr.current_ma, cur_tab[c]);
            chk("deglitch code", thr.dgl_us, 32'(c));
        end
        apb(1'b1, LFS_IDX, 32'h0F800000);
        smp(8'hFF, 10'h000, 11'h000);
        chk("fault disabled", fault, 4'h0);
        apb(1'b0, STS_IDX, 32'h00000000);
        chk("status disabled", rd, 32'h00000000);
        apb(1'b1, LFS_IDX, 32'h4F800000);
        smp(8'hC9, 10'h2A2, 11'h04A);
        chk("speed only", fault, 4'h1);
        apb(1'b1, LFS_IDX, 32'h7F800000);
        smp(8'hC9, 10'h2A2, 11'h04A);
        chk("fault all", fault, 4'h7);
        smp(8'hC8, 10'h2A3, 11'h04B);
        chk("fault edge", fault, 4'h0);
        apb(1'b0, STS_IDX, 32'h00000000);
        chk("status set", rd, 32'h00000007);
        apb(1'b1, MSK_IDX, 32'h00000001);
        #1;
        chk("irq unmasked", irq, 1'b1);
        apb(1'b0, MSK_IDX, 32'h00000000);
        chk("mask read", rd, 32'h00000001);
        apb(1'b1, STS_IDX, 32'h00000007);
        #1;
        chk("irq cleared", irq, 1'b0);
        apb(1'b0, STS_IDX, 32'h00000000);
        chk("status cleared", rd, 32'h00000000);
        apb(1'b0, 10'h000, 32'h00000000);
        chk("unmapped error", er, 1'b1);
        apb(1'b1, LFS_IDX, 32'h00001000);
        #1;
        meas.ilimit <= 1'b1;
        repeat (19) @(posedge pclk);
        #1;
        chk("deglitch early", fault[EV_HWLOCK], 1'b0);
        repeat (4) @(posedge pclk);
        #1;
        chk("deglitch late", fault[EV_HWLOCK], 1'b1);
        apb(1'b0, FLT_IDX, 32'h00000000);
        chk("fault read", rd, 32'h00000008);
        apb(1'b1, LFS_IDX, 32'h00049000);
        @(posedge pclk);
        #1;
        chk("action disabled", fault[EV_HWLOCK], 1'b0);
        meas.ilimit <= 1'b0;
        tally_and_finish();
    end
endmodule : tb_motor_lock_fault_config
